// >>> hw/aims_ch0_decode.sv
// Decodes a five-bit channel 0 positive select code into a source
`timescale 1ns/100ps
module aims_ch0_decode (
    input wire logic [4:0] code,
    output aims_pkg::aims_src_type src
);
    import aims_pkg::*;

    // Analog inputs, op amp outputs, temperature diode, open; others reserved
    always_comb begin
        if (code <= CH0_CODE_AN_MAX) begin
            src = aims_src_type'(code[3:0]);
        end else begin
            case (code)
                CH0_CODE_OA1: src = SRC_OA1;
                CH0_CODE_OA2: src = SRC_OA2;
                CH0_CODE_OA3: src = SRC_OA3;
                CH0_CODE_TEMP: src = SRC_TEMP;
                CH0_CODE_OPEN: src = SRC_OPEN;
                default: src = SRC_NONE; // Reserved codes connect nothing
            endcase
        end
    end
endmodule // aims_ch0_decode

// >>> hw/aims_pkg.sv
// Shared constants and types for the ADC input multiplexer selection block
package aims_pkg;

    // Avalon-MM geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_CH0_SEL = 8'h00;
    localparam logic [7:0] OFS_GROUP_SEL = 8'h04;
    localparam logic [7:0] OFS_SCAN_HIGH = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Writable bits of each register; the rest read as zero
    localparam logic [15:0] CH0_SEL_MASK = 16'h9f9f;
    localparam logic [15:0] GROUP_SEL_MASK = 16'h0707;
    localparam logic [15:0] SCAN_HIGH_MASK = 16'hc700;
    localparam logic [15:0] CTRL_MASK = 16'h001f;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // channel0_input_select fields
    localparam int unsigned CH0_NEG_B_BIT = 15;
    localparam int unsigned CH0_POS_B_LSB = 8;
    localparam int unsigned CH0_NEG_A_BIT = 7;
    localparam int unsigned CH0_POS_A_LSB = 0;
    localparam int unsigned CH0_POS_W = 5;

    // Group (channels 1-3) select fields
    localparam int unsigned GRP_POS_A_BIT = 0;
    localparam int unsigned GRP_NEG_A_LSB = 1;
    localparam int unsigned GRP_POS_B_BIT = 8;
    localparam int unsigned GRP_NEG_B_LSB = 9;
    localparam logic [1:0] GRP_NEG_ALT = 2'h2;
    localparam logic [1:0] GRP_NEG_RSVD = 2'h3;

    // scan_select_high fields
    localparam int unsigned SCAN_OA1_BIT = 8;
    localparam int unsigned SCAN_OA2_BIT = 9;
    localparam int unsigned SCAN_OA3_BIT = 10;
    localparam int unsigned SCAN_TEMP_BIT = 14;
    localparam int unsigned SCAN_SPARE_BIT = 15;
    localparam int unsigned SCAN_SLOTS = 5;

    // Control register fields
    localparam int unsigned CTRL_TWELVE_BIT = 0;
    localparam int unsigned CTRL_ALT_BIT = 1;
    localparam int unsigned CTRL_OAMODE_LSB = 2;

    // Status register fields
    localparam int unsigned STAT_SET_B_BIT = 0;
    localparam int unsigned STAT_SCAN_VALID_BIT = 1;
    localparam int unsigned STAT_SCAN_PTR_LSB = 4;
    localparam int unsigned STAT_SCAN_SRC_LSB = 8;
    localparam int unsigned STAT_CH0_SRC_LSB = 12;

    // Channel 0 positive select codes
    localparam logic [4:0] CH0_CODE_AN_MAX = 5'h08;
    localparam logic [4:0] CH0_CODE_OA1 = 5'h18;
    localparam logic [4:0] CH0_CODE_OA2 = 5'h19;
    localparam logic [4:0] CH0_CODE_OA3 = 5'h1a;
    localparam logic [4:0] CH0_CODE_TEMP = 5'h1e;
    localparam logic [4:0] CH0_CODE_OPEN = 5'h1f;

    // Source presented to the analog front end
    typedef enum logic [3:0] {
        SRC_AN0 = 4'h0,
        SRC_AN1 = 4'h1,
        SRC_AN2 = 4'h2,
        SRC_AN3 = 4'h3,
        SRC_AN4 = 4'h4,
        SRC_AN5 = 4'h5,
        SRC_AN6 = 4'h6,
        SRC_AN7 = 4'h7,
        SRC_AN8 = 4'h8,
        SRC_OA1 = 4'h9,
        SRC_OA2 = 4'ha,
        SRC_OA3 = 4'hb,
        SRC_TEMP = 4'hc,
        SRC_OPEN = 4'hd,
        SRC_LOWREF = 4'he,
        SRC_NONE = 4'hf
    } aims_src_type;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } aims_bus_type;

endpackage

// >>> hw/aims_shared_resolve.sv
// Resolves an op amp request on a shared op amp / analog input pin
`timescale 1ns/100ps
module aims_shared_resolve (
    input aims_pkg::aims_src_type src_in,
    input wire logic [2:0] opamp_mode_sel,
    output aims_pkg::aims_src_type src_out
);
    import aims_pkg::*;

    // Op amp output only when that op amp is in op amp mode, else the pin
    always_comb begin
        case (src_in)
            SRC_OA1: src_out = opamp_mode_sel[0] ? SRC_OA1 : SRC_AN3;
            SRC_OA2: src_out = opamp_mode_sel[1] ? SRC_OA2 : SRC_AN0;
            SRC_OA3: src_out = opamp_mode_sel[2] ? SRC_OA3 : SRC_AN6;
            default: src_out = src_in;
        endcase
    end
endmodule // aims_shared_resolve

// >>> hw/aims_top.sv
// ADC input multiplexer selection block with Avalon-MM register access
// Summary of operation
// - Twelve-bit mode: group selects read zero, unused
// - Group positive select routes OA1/OA2/OA3 or OA2/AN1/AN2
// - Group negative: 10 OA3/AN7/AN8, 0x low reference
// - Shared pins give op amp only in op amp mode
// - Channel 0 negative: 1 is AN1, 0 low reference
// - Channel 0 set B positive code decode
// - Channel 0 set A positive, same decode
// - Scan bit 14 includes temperature source
// - Scan bit 10 includes op amp 3/AN6
// - Scan bit 9 includes op amp 2/AN0
// - Alternate sampling swaps A and B each sample
// - Scan slot without input converts low reference
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
module aims_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [aims_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [aims_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [aims_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sample_done,
    input wire logic scan_restart,
    input wire logic scan_step,
    output aims_pkg::aims_src_type ch0_pos_src,
    output aims_pkg::aims_src_type ch0_neg_src,
    output aims_pkg::aims_src_type ch1_pos_src,
    output aims_pkg::aims_src_type ch2_pos_src,
    output aims_pkg::aims_src_type ch3_pos_src,
    output aims_pkg::aims_src_type ch1_neg_src,
    output aims_pkg::aims_src_type ch2_neg_src,
    output aims_pkg::aims_src_type ch3_neg_src,
    output aims_pkg::aims_src_type scan_src,
    output logic scan_valid,
    output logic active_set_b
);
    import aims_pkg::*;

    localparam int unsigned NRES = 6;
    localparam logic [2:0] SLOT_LAST = 3'(SCAN_SLOTS - 1);

    aims_bus_type bus_q;
    logic [REG_W-1:0] ch0_sel_q;
    logic [REG_W-1:0] group_sel_q;
    logic [REG_W-1:0] scan_high_q;
    logic [REG_W-1:0] ctrl_q;
    logic set_b_q;
    logic [2:0] scan_ptr_q;
    logic [2:0] scan_ptr_d;
    logic [SCAN_SLOTS-1:0] slot_en;
    aims_src_type slot_src [SCAN_SLOTS];
    logic [REG_W-1:0] wr_mask;
    logic [REG_W-1:0] group_eff;
    logic [REG_W-1:0] status_word;
    logic [REG_W-1:0] rd_word;
    logic bus_req;
    logic bus_take;
    logic twelve_bit_mode;
    logic alternate_sampling;
    logic [2:0] opamp_mode_sel;
    logic ch0_neg_sel;
    logic [4:0] ch0_pos_code;
    logic group_pos_sel;
    logic [1:0] group_neg_sel;
    aims_src_type ch0_pos_dec;
    aims_src_type res_in [NRES];
    aims_src_type res_out [NRES];
    aims_src_type grp_neg_2;
    aims_src_type grp_neg_3;

    // Control fields
    assign twelve_bit_mode = ctrl_q[CTRL_TWELVE_BIT];
    assign alternate_sampling = ctrl_q[CTRL_ALT_BIT];
    assign opamp_mode_sel = ctrl_q[CTRL_OAMODE_LSB +: 3];

    // ---------------------------------------------------------------
    // Avalon-MM slave: one wait state, then the request is taken
    // ---------------------------------------------------------------
    assign bus_req = avs_read | avs_write;
    assign bus_take = bus_req & (bus_q == BUS_ACK);
    assign avs_waitrequest = bus_req & (bus_q != BUS_ACK);

    // Bus state; BUS_ACK lasts exactly the cycle in which the master is released
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_q <= BUS_IDLE;
        end else begin
            case (bus_q)
                BUS_IDLE: bus_q <= bus_req ? BUS_ACK : BUS_IDLE;
                BUS_ACK: bus_q <= BUS_IDLE;
                default: bus_q <= BUS_IDLE;
            endcase
        end
    end

    // Byte lanes 0 and 1 cover the 16-bit registers; upper lanes are ignored
    assign wr_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Channel 0 select register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ch0_sel_q <= REG_RESET;
        end else if (bus_take && avs_write && avs_address == OFS_CH0_SEL) begin
            ch0_sel_q <= (ch0_sel_q & ~(wr_mask & CH0_SEL_MASK))
                | (avs_writedata[REG_W-1:0] & wr_mask & CH0_SEL_MASK);
        end
    end

    // Group select register; kept even in twelve-bit mode but masked on use
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            group_sel_q <= REG_RESET;
        end else if (bus_take && avs_write && avs_address == OFS_GROUP_SEL) begin
            group_sel_q <= (group_sel_q & ~(wr_mask & GROUP_SEL_MASK))
                | (avs_writedata[REG_W-1:0] & wr_mask & GROUP_SEL_MASK);
        end
    end

    // High scan select register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_high_q <= REG_RESET;
        end else if (bus_take && avs_write && avs_address == OFS_SCAN_HIGH) begin
            scan_high_q <= (scan_high_q & ~(wr_mask & SCAN_HIGH_MASK))
                | (avs_writedata[REG_W-1:0] & wr_mask & SCAN_HIGH_MASK);
        end
    end

    // Control register: resolution mode, alternate sampling, op amp modes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= REG_RESET;
        end else if (bus_take && avs_write && avs_address == OFS_CTRL) begin
            ctrl_q <= (ctrl_q & ~(wr_mask & CTRL_MASK))
                | (avs_writedata[REG_W-1:0] & wr_mask & CTRL_MASK);
        end
    end

    // Group fields vanish in twelve-bit mode, for reads and for routing
    assign group_eff = twelve_bit_mode ? REG_RESET : group_sel_q;

    // Status word shows the live selection state
    always_comb begin
        status_word = REG_RESET;
        status_word[STAT_SET_B_BIT] = set_b_q;
        status_word[STAT_SCAN_VALID_BIT] = scan_valid;
        status_word[STAT_SCAN_PTR_LSB +: 3] = scan_ptr_q;
        status_word[STAT_SCAN_SRC_LSB +: 4] = scan_src;
        status_word[STAT_CH0_SRC_LSB +: 4] = ch0_pos_src;
    end

    // Read decode; unmapped offsets read as zero
    always_comb begin
        case (avs_address)
            OFS_CH0_SEL: rd_word = ch0_sel_q;
            OFS_GROUP_SEL: rd_word = group_eff;
            OFS_SCAN_HIGH: rd_word = scan_high_q;
            OFS_CTRL: rd_word = ctrl_q;
            OFS_STATUS: rd_word = status_word;
            default: rd_word = REG_RESET;
        endcase
    end

    // Read data captured while waitrequest is high, stands at the release edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && bus_q == BUS_IDLE) begin
            avs_readdata <= {{(DATA_W - REG_W){1'b0}}, rd_word};
        end
    end

    // ---------------------------------------------------------------
    // Sample set tracking
    // ---------------------------------------------------------------
    // Toggles per finished sample; drops to set A as soon as alternation is off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            set_b_q <= 1'b0;
        end else if (!alternate_sampling) begin
            set_b_q <= 1'b0;
        end else if (sample_done) begin
            set_b_q <= ~set_b_q;
        end
    end

    // Pick the fields of the active sample set
    always_comb begin
        if (set_b_q) begin
            ch0_neg_sel = ch0_sel_q[CH0_NEG_B_BIT];
            ch0_pos_code = ch0_sel_q[CH0_POS_B_LSB +: CH0_POS_W];
            group_pos_sel = group_eff[GRP_POS_B_BIT];
            group_neg_sel = group_eff[GRP_NEG_B_LSB +: 2];
        end else begin
            ch0_neg_sel = ch0_sel_q[CH0_NEG_A_BIT];
            ch0_pos_code = ch0_sel_q[CH0_POS_A_LSB +: CH0_POS_W];
            group_pos_sel = group_eff[GRP_POS_A_BIT];
            group_neg_sel = group_eff[GRP_NEG_A_LSB +: 2];
        end
    end

    // Channel 0 positive code decode
    aims_ch0_decode u_ch0_decode (
        .code(ch0_pos_code),
        .src(ch0_pos_dec)
    );

    // Requests that may name a shared pin, before op amp mode is applied
    always_comb begin
        res_in[0] = ch0_pos_dec;
        res_in[1] = group_pos_sel ? SRC_OA1 : SRC_OA2;
        res_in[2] = group_pos_sel ? SRC_OA2 : SRC_AN1;
        res_in[3] = group_pos_sel ? SRC_OA3 : SRC_AN2;
        case (group_neg_sel)
            GRP_NEG_ALT: res_in[4] = SRC_OA3;
            GRP_NEG_RSVD: res_in[4] = SRC_NONE;
            default: res_in[4] = SRC_LOWREF;
        endcase
        res_in[5] = slot_src[scan_ptr_q];
    end

    // Channels 2 and 3 negative inputs never touch a shared pin
    always_comb begin
        case (group_neg_sel)
            GRP_NEG_ALT: begin
                grp_neg_2 = SRC_AN7;
                grp_neg_3 = SRC_AN8;
            end
            GRP_NEG_RSVD: begin
                grp_neg_2 = SRC_NONE;
                grp_neg_3 = SRC_NONE;
            end
            default: begin
                grp_neg_2 = SRC_LOWREF;
                grp_neg_3 = SRC_LOWREF;
            end
        endcase
    end

    // One resolver per path that can land on a shared pin
    for (genvar i = 0; i < NRES; i++) begin : g_resolve
        aims_shared_resolve u_resolve (
            .src_in(res_in[i]),
            .opamp_mode_sel(opamp_mode_sel),
            .src_out(res_out[i])
        );
    end

    // ---------------------------------------------------------------
    // Input scan over the high scan select bits
    // ---------------------------------------------------------------
    // Slots in ascending bit order; the spare top bit has no input behind it
    always_comb begin
        slot_en[0] = scan_high_q[SCAN_OA1_BIT];
        slot_en[1] = scan_high_q[SCAN_OA2_BIT];
        slot_en[2] = scan_high_q[SCAN_OA3_BIT];
        slot_en[3] = scan_high_q[SCAN_TEMP_BIT];
        slot_en[4] = scan_high_q[SCAN_SPARE_BIT];
        slot_src[0] = SRC_OA1;
        slot_src[1] = SRC_OA2;
        slot_src[2] = SRC_OA3;
        slot_src[3] = SRC_TEMP;
        slot_src[4] = SRC_LOWREF;
    end

    // Next enabled slot after the current one, wrapping; a restart begins at slot 0
    always_comb begin
        logic [2:0] cand;
        logic found;
        cand = scan_ptr_q;
        found = 1'b0;
        scan_ptr_d = scan_ptr_q;
        for (int k = 1; k <= SCAN_SLOTS; k++) begin
            if (scan_restart) begin
                cand = 3'(k - 1);
            end else if (cand == SLOT_LAST) begin
                cand = 3'h0;
            end else begin
                cand = cand + 3'h1;
            end
            if (!found && slot_en[cand]) begin
                scan_ptr_d = cand;
                found = 1'b1;
            end
        end
    end

    // Scan pointer moves only on restart or step, so a slot disabled under it stays current
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_ptr_q <= 3'h0;
        end else if (scan_restart || scan_step) begin
            scan_ptr_q <= scan_ptr_d;
        end
    end

    // ---------------------------------------------------------------
    // Registered selections toward the analog front end
    // ---------------------------------------------------------------
    // One cycle of latency buys glitch-free mux control lines
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ch0_pos_src <= SRC_AN0;
            ch0_neg_src <= SRC_LOWREF;
            ch1_pos_src <= SRC_AN0;
            ch2_pos_src <= SRC_AN1;
            ch3_pos_src <= SRC_AN2;
            ch1_neg_src <= SRC_LOWREF;
            ch2_neg_src <= SRC_LOWREF;
            ch3_neg_src <= SRC_LOWREF;
        end else begin
            ch0_pos_src <= res_out[0];
            ch0_neg_src <= ch0_neg_sel ? SRC_AN1 : SRC_LOWREF;
            ch1_pos_src <= res_out[1];
            ch2_pos_src <= res_out[2];
            ch3_pos_src <= res_out[3];
            ch1_neg_src <= res_out[4];
            ch2_neg_src <= grp_neg_2;
            ch3_neg_src <= grp_neg_3;
        end
    end

    // Scan output; a disabled current slot is reported invalid, not converted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_src <= SRC_LOWREF;
            scan_valid <= 1'b0;
        end else begin
            scan_src <= res_out[5];
            scan_valid <= slot_en[scan_ptr_q];
        end
    end

    // Active set flag for the converter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_set_b <= 1'b0;
        end else begin
            active_set_b <= set_b_q;
        end
    end

endmodule // aims_top

// >>> test/aims_frontend_model.sv
// Converter front end model that paces samples and scan steps
`timescale 1ns/100ps
module aims_frontend_model (
    input wire logic clk,
    output logic sample_done,
    output logic scan_restart,
    output logic scan_step
);
    // Strobes rest low until a conversion event
    initial begin
        sample_done = 1'b0;
        scan_restart = 1'b0;
        scan_step = 1'b0;
    end

    // One-cycle strobe after a gap; 0 sample, 1 restart, 2 step
    task automatic pulse(input int which, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        sample_done <= (which == 0);
        scan_restart <= (which == 1);
        scan_step <= (which == 2);
        @(posedge clk);
        sample_done <= 1'b0;
        scan_restart <= 1'b0;
        scan_step <= 1'b0;
    endtask
endmodule // aims_frontend_model

// >>> test/aims_top_properties.sv
// Concurrent checks on the selection outputs of the multiplexer block
`timescale 1ns/100ps
module aims_top_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample_done,
    input aims_pkg::aims_src_type ch0_pos_src,
    input aims_pkg::aims_src_type ch0_neg_src,
    input aims_pkg::aims_src_type ch1_pos_src,
    input aims_pkg::aims_src_type ch2_pos_src,
    input aims_pkg::aims_src_type ch3_pos_src,
    input aims_pkg::aims_src_type ch1_neg_src,
    input aims_pkg::aims_src_type ch2_neg_src,
    input aims_pkg::aims_src_type ch3_neg_src,
    input aims_pkg::aims_src_type scan_src,
    input wire logic scan_valid,
    input wire logic active_set_b
);
    import aims_pkg::*;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_ch0_neg;
        ch0_neg_src inside {SRC_AN1, SRC_LOWREF};
    endproperty
    a_ch0_neg: assert property (p_ch0_neg) else $error("channel 0 negative source illegal");
    property p_ch0_pos;
        ch0_pos_src != SRC_LOWREF;
    endproperty
    a_ch0_pos: assert property (p_ch0_pos) else $error("channel 0 positive took low reference");
    property p_grp_pos;
        (ch2_pos_src == SRC_AN1) == (ch3_pos_src == SRC_AN2);
    endproperty
    a_grp_pos: assert property (p_grp_pos) else $error("group positive channels disagree");
    property p_grp_neg;
        (ch2_neg_src == SRC_AN7) == (ch3_neg_src == SRC_AN8);
    endproperty
    a_grp_neg: assert property (p_grp_neg) else $error("group negative channels disagree");
    property p_shared;
        ch1_pos_src inside {SRC_OA1, SRC_AN3, SRC_OA2, SRC_AN0};
    endproperty
    a_shared: assert property (p_shared) else $error("channel 1 positive source illegal");
    property p_neg_pair;
        (ch1_neg_src inside {SRC_OA3, SRC_AN6}) == (ch2_neg_src == SRC_AN7);
    endproperty
    a_neg_pair: assert property (p_neg_pair) else $error("channel 1 negative out of step");
    property p_scan;
        scan_valid |-> scan_src inside {SRC_AN0, SRC_AN3, SRC_AN6, SRC_OA1, SRC_OA2, SRC_OA3, SRC_TEMP, SRC_LOWREF};
    endproperty
    a_scan: assert property (p_scan) else $error("scan slot source illegal");
    // Set B only ever follows a finished sample two edges back
    property p_alt;
        $rose(active_set_b) |-> $past(sample_done, 2);
    endproperty
    a_alt: assert property (p_alt) else $error("set B taken without a sample");
endmodule // aims_top_properties

bind aims_top aims_top_properties u_aims_top_properties (
    .clk, .rst_n, .sample_done, .ch0_pos_src, .ch0_neg_src, .ch1_pos_src, .ch2_pos_src,
    .ch3_pos_src, .ch1_neg_src, .ch2_neg_src, .ch3_neg_src, .scan_src, .scan_valid, .active_set_b
);

// >>> test/test_aims_top.sv
// Self-checking testbench for the input multiplexer selection block
`timescale 1ns/100ps
`define CHECK_EQ(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_aims_top;
    import aims_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sample_done, scan_restart, scan_step, scan_valid, active_set_b;
    aims_src_type ch0_pos_src, ch0_neg_src, ch1_pos_src, ch2_pos_src, ch3_pos_src;
    aims_src_type ch1_neg_src, ch2_neg_src, ch3_neg_src, scan_src;
    int bad_count = 0;
    int checked = 0;
    logic [31:0] v;
    logic [2:0] mode = 3'b000;

    aims_top u_aims_top (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .sample_done, .scan_restart, .scan_step,
        .ch0_pos_src, .ch0_neg_src, .ch1_pos_src, .ch2_pos_src, .ch3_pos_src, .ch1_neg_src,
        .ch2_neg_src, .ch3_neg_src, .scan_src, .scan_valid, .active_set_b);
    aims_frontend_model u_aims_frontend_model (.clk, .sample_done, .scan_restart, .scan_step);

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    // Shared op amp pin: op amp output only when its mode bit is set
    function automatic aims_src_type sh(input int k);
        aims_src_type pin[3] = '{SRC_AN3, SRC_AN0, SRC_AN6};
        return mode[k - 1] ? aims_src_type'(k + 8) : pin[k - 1];
    endfunction

    // Expected channel 0 positive source for a select code
    function automatic aims_src_type c0(input logic [4:0] c);
        if (c <= 5'h08) return aims_src_type'(c[3:0]);
        if (c inside {5'h18, 5'h19, 5'h1a}) return sh(int'(c) - 23);
        if (c == 5'h1e) return SRC_TEMP;
        if (c == 5'h1f) return SRC_OPEN;
        return SRC_NONE;
    endfunction

    // One bus access; the request stands until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) bad_count++;
        v = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Registered outputs land one edge after the cause; look mid-cycle
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Hang guard, far beyond the fewer than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        automatic logic [4:0] codes[17] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
            5'h09, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1d, 5'h1e, 5'h1f};
        automatic logic [7:0] ofs[3] = '{OFS_CH0_SEL, OFS_SCAN_HIGH, 8'h14};
        automatic logic [15:0] msk[3] = '{CH0_SEL_MASK, SCAN_HIGH_MASK, 16'h0000};
        aims_src_type fb;
        aims_src_type seq[6];
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, unwritable bits and an unmapped slot
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, ofs[i], 16'h0);
            `CHECK_EQ(v, 32'h0);
            bus(1'b1, ofs[i], 16'hffff);
            bus(1'b0, ofs[i], 16'h0);
            `CHECK_EQ(v, {16'h0, msk[i]});
        end
        // Set A decode with op amps off, then all on
        for (int m = 0; m < 8; m += 7) begin
            mode = 3'(m);
            bus(1'b1, OFS_CTRL, {11'h0, mode, 2'b00});
            foreach (codes[i]) begin
                bus(1'b1, OFS_CH0_SEL, {8'h00, 1'(i), 2'b00, codes[i]});
                settle();
                `CHECK_EQ(ch0_pos_src, c0(codes[i]));
                `CHECK_EQ(ch0_neg_src, i % 2 ? SRC_AN1 : SRC_LOWREF);
            end
        end
        // Alternation flips sets per sample, slow and prompt samples alike
        bus(1'b1, OFS_CTRL, {11'h0, mode, 2'b10});
        foreach (codes[i]) begin
            bus(1'b1, OFS_CH0_SEL, {1'b1, 2'b00, codes[i], 8'h02});
            u_aims_frontend_model.pulse(0, i % 3);
            settle();
            `CHECK_EQ(active_set_b, 1'b1);
            `CHECK_EQ(ch0_pos_src, c0(codes[i]));
            `CHECK_EQ(ch0_neg_src, SRC_AN1);
            u_aims_frontend_model.pulse(0, 0);
            settle();
            `CHECK_EQ(ch0_pos_src, SRC_AN2);
        end
        // Leave set B active so that turning alternation off must pull it back
        u_aims_frontend_model.pulse(0, 0);
        bus(1'b1, OFS_CTRL, {11'h0, mode, 2'b00});
        u_aims_frontend_model.pulse(0, 1);
        settle();
        `CHECK_EQ(active_set_b, 1'b0);
        // Every set A group select code, op amps off then on
        for (int m = 0; m < 8; m += 7) begin
            mode = 3'(m);
            bus(1'b1, OFS_CTRL, {11'h0, mode, 2'b00});
            for (int g = 0; g < 8; g++) begin
                bus(1'b1, OFS_GROUP_SEL, 16'(g));
                settle();
                fb = g[2] ? SRC_NONE : SRC_LOWREF;
                `CHECK_EQ(ch1_pos_src, g[0] ? sh(1) : sh(2));
                `CHECK_EQ(ch2_pos_src, g[0] ? sh(2) : SRC_AN1);
                `CHECK_EQ(ch3_pos_src, g[0] ? sh(3) : SRC_AN2);
                `CHECK_EQ(ch1_neg_src, g[2:1] == 2'b10 ? sh(3) : fb);
                `CHECK_EQ(ch2_neg_src, g[2:1] == 2'b10 ? SRC_AN7 : fb);
                `CHECK_EQ(ch3_neg_src, g[2:1] == 2'b10 ? SRC_AN8 : fb);
            end
        end
        // Twelve-bit mode hides the group select and routes it as zero
        mode = 3'b000;
        bus(1'b1, OFS_CTRL, 16'h0001);
        settle();
        bus(1'b0, OFS_GROUP_SEL, 16'h0);
        `CHECK_EQ(v, 32'h0);
        `CHECK_EQ(ch1_pos_src, SRC_AN0);
        // Scan walk over all slots with wrap, then a sparse selection
        mode = 3'b010;
        bus(1'b1, OFS_CTRL, {11'h0, mode, 2'b00});
        seq = '{sh(1), sh(2), sh(3), SRC_TEMP, SRC_LOWREF, sh(1)};
        for (int p = 0; p < 2; p++) begin
            if (p == 1) seq = '{sh(2), SRC_TEMP, sh(2), SRC_TEMP, sh(2), SRC_TEMP};
            bus(1'b1, OFS_SCAN_HIGH, p ? 16'h4200 : 16'hc700);
            u_aims_frontend_model.pulse(1, p);
            foreach (seq[i]) begin
                settle();
                `CHECK_EQ(scan_src, seq[i]);
                `CHECK_EQ(scan_valid, 1'b1);
                u_aims_frontend_model.pulse(2, i % 2);
            end
        end
        // Skipped slot under the pointer turns invalid; status shows slot 1, OA2, AN2
        bus(1'b1, OFS_SCAN_HIGH, 16'h0000);
        settle();
        `CHECK_EQ(scan_valid, 1'b0);
        bus(1'b0, OFS_STATUS, 16'h0);
        `CHECK_EQ(v, 32'h00002a10);
        tally_and_finish();
    end
endmodule // test_aims_top
